// ---- rtl/rcg_div_if.sv ----
// link between the control block and the divider core
// assumes both ends run on the register clock
interface rcg_div_if
	import rcg_pkg::*;
	();
	logic                  src_edge;
	logic                  src_level;
	logic                  run;
	logic                  load;
	logic [RCG_DIV_W-1:0]  div;
	logic [RCG_TRIM_W-1:0] trim;
	logic                  ack;
	logic                  out;

	modport ctl (output src_edge, src_level, run, load, div, trim, input ack, out);
	modport gen (input src_edge, src_level, run, load, div, trim, output ack, out);
endinterface

// ---- rtl/rcg_divider.sv ----
// divider core: counts selected source edges into the reference output
// assumes src_edge marks one rising source edge per pulse, on the register clock
module rcg_divider
	import rcg_pkg::*;
	(
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	// control side
	rcg_div_if.gen   div_if
	);

	logic [RCG_DIV_W-1:0]  div_reg,   div_next;
	logic [RCG_TRIM_W-1:0] trim_reg,  trim_next;
	logic [RCG_TRIM_W-1:0] acc_reg,   acc_next;
	logic [RCG_DIV_W:0]    cnt_reg,   cnt_next;
	logic                  out_reg,   out_next;
	logic                  ack_reg,   ack_next;
	logic                  carry_reg, carry_next;

	always_comb
	begin
		logic [RCG_TRIM_W:0] sum;
		logic [RCG_DIV_W:0]  half_len;
		logic                boundary;
		sum        = {1'b0, acc_reg} + {1'b0, trim_reg};
		half_len   = {1'b0, div_reg} + {{RCG_DIV_W{1'b0}}, carry_reg};
		boundary   = 1'b0;
		div_next   = div_reg;
		trim_next  = trim_reg;
		acc_next   = acc_reg;
		cnt_next   = cnt_reg;
		out_next   = out_reg;
		ack_next   = 1'b0;
		carry_next = carry_reg;
		// a stopped output finishes its high half first, so no runt pulse
		if (div_reg == '0)
		begin
			// undivided: follow the level, both halves, not just the rise
			out_next = div_if.src_level & (div_if.run | out_reg);
			boundary = div_if.src_edge;
		end
		else if (div_if.src_edge && (div_if.run || out_reg))
		begin
			if (cnt_reg + 1'b1 >= half_len)
			begin
				out_next   = ~out_reg & div_if.run;
				cnt_next   = '0;
				acc_next   = sum[RCG_TRIM_W-1:0];
				carry_next = sum[RCG_TRIM_W];
				boundary   = 1'b1;
			end
			else
				cnt_next = cnt_reg + 1'b1;
		end
		// new ratio only at a half-period edge or while idle
		if (div_if.load && (boundary || (!div_if.run && !out_reg)))
		begin
			div_next   = div_if.div;
			trim_next  = (div_if.div == '0) ? '0 : div_if.trim;
			acc_next   = '0;
			cnt_next   = '0;
			carry_next = 1'b0;
			ack_next   = 1'b1;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			div_reg   <= '0;
			trim_reg  <= '0;
			acc_reg   <= '0;
			cnt_reg   <= '0;
			out_reg   <= 1'b0;
			ack_reg   <= 1'b0;
			carry_reg <= 1'b0;
		end
		else if (i_clk_en)
		begin
			div_reg   <= div_next;
			trim_reg  <= trim_next;
			acc_reg   <= acc_next;
			cnt_reg   <= cnt_next;
			out_reg   <= out_next;
			ack_reg   <= ack_next;
			carry_reg <= carry_next;
		end
	end

	assign div_if.out = out_reg;
	assign div_if.ack = ack_reg;
endmodule

// ---- rtl/rcg_pkg.sv ----
// constants for the reference clock output generator
// assumes a single 125 MHz register clock and a 32-bit avalon-mm slave port
package rcg_pkg;
	// register byte offsets
	localparam logic [3:0] RCG_OFF_CTRL_LOW  = 4'h0;
	localparam logic [3:0] RCG_OFF_CTRL_HIGH = 4'h4;
	localparam logic [3:0] RCG_OFF_TRIM      = 4'h8;

	// control low fields
	localparam int RCG_BIT_ENABLE      = 15;
	localparam int RCG_BIT_IDLE_STOP   = 13;
	localparam int RCG_BIT_PIN_DRIVE   = 12;
	localparam int RCG_BIT_SLEEP_RUN   = 11;
	localparam int RCG_BIT_SWITCH_REQ  = 9;
	localparam int RCG_BIT_ACTIVE      = 8;
	localparam int RCG_SEL_MSB         = 3;
	localparam int RCG_SEL_LSB         = 0;

	// control high and trim fields
	localparam int RCG_DIV_W           = 15;
	localparam int RCG_DIV_LSB         = 0;
	localparam int RCG_TRIM_W          = 9;
	localparam int RCG_TRIM_LSB        = 7;

	// reset values
	localparam logic [15:0] RCG_RST_CTRL_LOW  = 16'h0000;
	localparam logic [15:0] RCG_RST_CTRL_HIGH = 16'h0000;
	localparam logic [15:0] RCG_RST_TRIM      = 16'h0000;

	// source select codes
	localparam logic [3:0] RCG_SRC_SYSCLK = 4'h0;
	localparam logic [3:0] RCG_SRC_PRIMARY_OSCILLATOR   = 4'h2;
	localparam logic [3:0] RCG_SRC_FRC    = 4'h3;
	localparam logic [3:0] RCG_SRC_LOW_POWER_RC_OSCILLATOR   = 4'h4;
	localparam logic [3:0] RCG_SRC_SECONDARY_OSCILLATOR   = 4'h5;
	localparam logic [3:0] RCG_SRC_PLL    = 4'h6;
	localparam logic [3:0] RCG_SRC_REFIN  = 4'h8;

	// synchronised source lanes
	localparam int RCG_NUM_SRC = 7;
	typedef enum logic [2:0] {
		RCG_LANE_SYS,
		RCG_LANE_PRIMARY_OSCILLATOR,
		RCG_LANE_FRC,
		RCG_LANE_LOW_POWER_RC_OSCILLATOR,
		RCG_LANE_SECONDARY_OSCILLATOR,
		RCG_LANE_PLL,
		RCG_LANE_REFIN
	} rcg_lane_t;
endpackage

// ---- rtl/rcg_refclk_gen.sv ----
// reference clock output generator: registers, source select, power gating, pin
// assumes source clocks are asynchronous and far slower than i_ref_clk
// Behaviour
// - enable bit starts and stops the generator
// - high register bits 14:0 hold divider
// - zero passes through, n divides by 2n
// - nine-bit trim adds fractional period
// - switch request applies values, hardware clears it
// - four-bit select picks the clock source
// - select zero follows the system clock
// - sleep-run bit keeps output during sleep when the selected source runs in sleep; never for select zero
// - pin-drive bit gates clock onto pin
// - active status set while on, clears after disable
// - split routes the pll select code to the system clock lane
// - half-rate system output runs independently
module rcg_refclk_gen
	import rcg_pkg::*;
	(
	// clock, reset, enable
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_clk_en,
	// avalon-mm slave
	input  wire logic [3:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	input  wire logic [3:0]  i_avs_byteenable,
	output logic      [31:0] o_avs_readdata,
	output logic             o_avs_waitrequest,
	// clock sources, asynchronous
	input  wire logic        i_sysclk,
	input  wire logic        i_primary_oscillator,
	input  wire logic        i_fast_rc_oscillator,
	input  wire logic        i_low_power_rc_oscillator,
	input  wire logic        i_secondary_oscillator,
	input  wire logic        i_pll_clk,
	input  wire logic        i_refclk_input_pin,
	// power and configuration, same clock
	input  wire logic        i_idle_mode,
	input  wire logic        i_sleep_mode,
	input  wire logic [6:0]  i_src_runs_in_sleep,
	input  wire logic        i_pll_source_split,
	input  wire logic        i_sysclk_output_config,
	// pins
	output logic             o_refclk_output_pin,
	output logic             o_refclk_output_oe,
	output logic             o_sysclk_half_output,
	output logic             o_pll_primary_excluded
	);

	rcg_div_if div_if ();

	// source synchronisers, one lane per source
	logic [RCG_NUM_SRC-1:0] src_raw;
	logic [RCG_NUM_SRC-1:0] sync1_reg;
	logic [RCG_NUM_SRC-1:0] sync2_reg;
	logic [RCG_NUM_SRC-1:0] sync3_reg;

	assign src_raw[RCG_LANE_SYS]   = i_sysclk;
	assign src_raw[RCG_LANE_PRIMARY_OSCILLATOR]  = i_primary_oscillator;
	assign src_raw[RCG_LANE_FRC]   = i_fast_rc_oscillator;
	assign src_raw[RCG_LANE_LOW_POWER_RC_OSCILLATOR]  = i_low_power_rc_oscillator;
	assign src_raw[RCG_LANE_SECONDARY_OSCILLATOR]  = i_secondary_oscillator;
	assign src_raw[RCG_LANE_PLL]   = i_pll_clk;
	assign src_raw[RCG_LANE_REFIN] = i_refclk_input_pin;

	genvar g;
	generate
		for (g = 0; g < RCG_NUM_SRC; g++)
		begin : g_sync
			always_ff @(posedge i_ref_clk or negedge i_rst_n)
			begin
				if (!i_rst_n)
				begin
					sync1_reg[g] <= 1'b0;
					sync2_reg[g] <= 1'b0;
					sync3_reg[g] <= 1'b0;
				end
				else if (i_clk_en)
				begin
					sync1_reg[g] <= src_raw[g];
					sync2_reg[g] <= sync1_reg[g];
					sync3_reg[g] <= sync2_reg[g];
				end
			end
		end
	endgenerate

	// register state
	logic                  enable_reg,     enable_next;
	logic                  idle_stop_reg,  idle_stop_next;
	logic                  pin_drive_reg,  pin_drive_next;
	logic                  sleep_run_reg,  sleep_run_next;
	logic                  switch_reg,     switch_next;
	logic                  active_reg,     active_next;
	logic [3:0]            sel_reg,        sel_next;
	logic [RCG_DIV_W-1:0]  div_reg,        div_next;
	logic [RCG_TRIM_W-1:0] trim_reg,       trim_next;
	logic [31:0]           rdata_reg,      rdata_next;
	logic                  wait_reg,       wait_next;
	logic                  pin_reg,        pin_next;
	logic                  oe_reg,         oe_next;
	logic                  half_reg,       half_next;
	logic                  excl_reg,       excl_next;

	// bus decode
	logic        req;
	logic        wr_take;
	logic [15:0] ctrl_low_rd;
	logic [15:0] ctrl_high_rd;
	logic [15:0] trim_rd;
	logic [15:0] wmask;
	logic [15:0] ctrl_low_wr;
	logic [15:0] ctrl_high_wr;
	logic [15:0] trim_wr;

	assign req     = i_avs_read | i_avs_write;
	assign wr_take = i_avs_write & ~wait_reg;
	assign wmask   = {{8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};

	always_comb
	begin
		ctrl_low_rd = '0;
		ctrl_low_rd[RCG_BIT_ENABLE]     = enable_reg;
		ctrl_low_rd[RCG_BIT_IDLE_STOP]  = idle_stop_reg;
		ctrl_low_rd[RCG_BIT_PIN_DRIVE]  = pin_drive_reg;
		ctrl_low_rd[RCG_BIT_SLEEP_RUN]  = sleep_run_reg;
		ctrl_low_rd[RCG_BIT_SWITCH_REQ] = switch_reg;
		ctrl_low_rd[RCG_BIT_ACTIVE]     = active_reg;
		ctrl_low_rd[RCG_SEL_MSB:RCG_SEL_LSB] = sel_reg;
		ctrl_high_rd = '0;
		ctrl_high_rd[RCG_DIV_LSB +: RCG_DIV_W] = div_reg;
		trim_rd = '0;
		trim_rd[RCG_TRIM_LSB +: RCG_TRIM_W] = trim_reg;
	end

	// byte lanes merge over the current image, so a half write keeps the rest
	always_comb
	begin
		ctrl_low_wr  = (ctrl_low_rd  & ~wmask) | (i_avs_writedata[15:0] & wmask);
		ctrl_high_wr = (ctrl_high_rd & ~wmask) | (i_avs_writedata[15:0] & wmask);
		trim_wr      = (trim_rd      & ~wmask) | (i_avs_writedata[15:0] & wmask);
	end

	// bus handshake: one wait cycle, then the answer cycle
	logic req_seen;
	logic hit_low;
	logic hit_high;
	logic hit_trim;
	assign req_seen = req & wait_reg;
	assign hit_low  = (i_avs_address == RCG_OFF_CTRL_LOW);
	assign hit_high = (i_avs_address == RCG_OFF_CTRL_HIGH);
	assign hit_trim = (i_avs_address == RCG_OFF_TRIM);

	always_comb
	begin
		wait_next  = ~req_seen;
		rdata_next = rdata_reg;
		if (i_avs_read && wait_reg)
		begin
			if (hit_low)
				rdata_next = {16'h0000, ctrl_low_rd};
			else if (hit_high)
				rdata_next = {16'h0000, ctrl_high_rd};
			else if (hit_trim)
				rdata_next = {16'h0000, trim_rd};
			else
				rdata_next = 32'h0000_0000;
		end
	end

	// power gating of the generator
	rcg_lane_t sel_lane;
	logic      src_sleeps_ok;
	logic      sleep_block;
	logic      idle_block;
	logic      run;
	// split passed in, so a config change re-evaluates the lane at once
	assign sel_lane      = lane_of(sel_reg, i_pll_source_split);
	assign src_sleeps_ok = (sel_reg == RCG_SRC_SYSCLK) ? 1'b0 : i_src_runs_in_sleep[sel_lane];
	assign sleep_block   = i_sleep_mode & ~(sleep_run_reg & src_sleeps_ok);
	assign idle_block    = i_idle_mode & idle_stop_reg;
	assign run           = enable_reg & ~sleep_block & ~idle_block;

	// lane for a select code; reserved codes fall through to the system lane
	function automatic rcg_lane_t lane_of(input logic [3:0] code, input logic split);
		unique case (code)
			RCG_SRC_PRIMARY_OSCILLATOR:  lane_of = RCG_LANE_PRIMARY_OSCILLATOR;
			RCG_SRC_FRC:   lane_of = RCG_LANE_FRC;
			RCG_SRC_LOW_POWER_RC_OSCILLATOR:  lane_of = RCG_LANE_LOW_POWER_RC_OSCILLATOR;
			RCG_SRC_SECONDARY_OSCILLATOR:  lane_of = RCG_LANE_SECONDARY_OSCILLATOR;
			RCG_SRC_PLL:   lane_of = split ? RCG_LANE_SYS : RCG_LANE_PLL;
			RCG_SRC_REFIN: lane_of = RCG_LANE_REFIN;
			default:       lane_of = RCG_LANE_SYS;
		endcase
	endfunction

	// source selection; edge taken from the second and third stages only
	logic sel_valid;
	logic sel_level;
	logic sel_edge;
	always_comb
	begin
		unique case (sel_reg)
			RCG_SRC_SYSCLK, RCG_SRC_PRIMARY_OSCILLATOR, RCG_SRC_FRC, RCG_SRC_LOW_POWER_RC_OSCILLATOR,
			RCG_SRC_SECONDARY_OSCILLATOR, RCG_SRC_PLL, RCG_SRC_REFIN: sel_valid = 1'b1;
			default:                                  sel_valid = 1'b0;
		endcase
		sel_level = sel_valid & sync2_reg[sel_lane];
		sel_edge  = sel_valid & sync2_reg[sel_lane] & ~sync3_reg[sel_lane];
	end

	assign div_if.src_edge  = sel_edge;
	assign div_if.src_level = sel_level;
	assign div_if.run       = run;
	assign div_if.load      = switch_reg;
	assign div_if.div       = div_reg;
	assign div_if.trim      = trim_reg;

	rcg_divider u_divider (
		.i_ref_clk (i_ref_clk),
		.i_rst_n   (i_rst_n),
		.i_clk_en  (i_clk_en),
		.div_if    (div_if.gen)
	);

	// register writes and status
	always_comb
	begin
		enable_next    = enable_reg;
		idle_stop_next = idle_stop_reg;
		pin_drive_next = pin_drive_reg;
		sleep_run_next = sleep_run_reg;
		sel_next       = sel_reg;
		div_next       = div_reg;
		trim_next      = trim_reg;
		// hardware clears on completion; a same-cycle software set wins
		switch_next    = switch_reg & ~div_if.ack;
		if (wr_take)
		begin
			unique case (i_avs_address)
				RCG_OFF_CTRL_LOW:
				begin
					enable_next    = ctrl_low_wr[RCG_BIT_ENABLE];
					idle_stop_next = ctrl_low_wr[RCG_BIT_IDLE_STOP];
					pin_drive_next = ctrl_low_wr[RCG_BIT_PIN_DRIVE];
					sleep_run_next = ctrl_low_wr[RCG_BIT_SLEEP_RUN];
					sel_next       = ctrl_low_wr[RCG_SEL_MSB:RCG_SEL_LSB];
					if (ctrl_low_wr[RCG_BIT_SWITCH_REQ])
						switch_next = 1'b1;
				end
				RCG_OFF_CTRL_HIGH: div_next  = ctrl_high_wr[RCG_DIV_LSB +: RCG_DIV_W];
				RCG_OFF_TRIM:      trim_next = trim_wr[RCG_TRIM_LSB +: RCG_TRIM_W];
				default:           ;
			endcase
		end
		// stays set until disabled and the last high half has drained
		active_next = enable_reg | div_if.out;
	end

	// pin side, all registered
	always_comb
	begin
		pin_next  = div_if.out & pin_drive_reg;
		oe_next   = pin_drive_reg;
		half_next = i_sysclk_output_config ? ~half_reg : 1'b0;
		excl_next = ~i_pll_source_split;
	end

	// register group
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			enable_reg    <= RCG_RST_CTRL_LOW[RCG_BIT_ENABLE];
			idle_stop_reg <= RCG_RST_CTRL_LOW[RCG_BIT_IDLE_STOP];
			pin_drive_reg <= RCG_RST_CTRL_LOW[RCG_BIT_PIN_DRIVE];
			sleep_run_reg <= RCG_RST_CTRL_LOW[RCG_BIT_SLEEP_RUN];
			switch_reg    <= RCG_RST_CTRL_LOW[RCG_BIT_SWITCH_REQ];
			active_reg    <= RCG_RST_CTRL_LOW[RCG_BIT_ACTIVE];
			sel_reg       <= RCG_RST_CTRL_LOW[RCG_SEL_MSB:RCG_SEL_LSB];
			div_reg       <= RCG_RST_CTRL_HIGH[RCG_DIV_LSB +: RCG_DIV_W];
			trim_reg      <= RCG_RST_TRIM[RCG_TRIM_LSB +: RCG_TRIM_W];
		end
		else if (i_clk_en)
		begin
			enable_reg    <= enable_next;
			idle_stop_reg <= idle_stop_next;
			pin_drive_reg <= pin_drive_next;
			sleep_run_reg <= sleep_run_next;
			switch_reg    <= switch_next;
			active_reg    <= active_next;
			sel_reg       <= sel_next;
			div_reg       <= div_next;
			trim_reg      <= trim_next;
		end
	end

	// bus group; waitrequest idles high so no answer leaks out of reset
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			rdata_reg <= 32'h0000_0000;
			wait_reg  <= 1'b1;
		end
		else if (i_clk_en)
		begin
			rdata_reg <= rdata_next;
			wait_reg  <= wait_next;
		end
	end

	// pin group
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			pin_reg  <= 1'b0;
			oe_reg   <= 1'b0;
			half_reg <= 1'b0;
			excl_reg <= 1'b0;
		end
		else if (i_clk_en)
		begin
			pin_reg  <= pin_next;
			oe_reg   <= oe_next;
			half_reg <= half_next;
			excl_reg <= excl_next;
		end
	end

	assign o_avs_readdata         = rdata_reg;
	assign o_avs_waitrequest      = wait_reg;
	assign o_refclk_output_pin    = pin_reg;
	assign o_refclk_output_oe     = oe_reg;
	assign o_sysclk_half_output   = half_reg;
	assign o_pll_primary_excluded = excl_reg;
endmodule

// ---- tb/rcg_ext_device.sv ----
// external load clocked from the reference output pin
// assumes ns time; reports edge count and last period
module rcg_ext_device
	(
	// pin side
	input  wire logic i_refclk_output_pin,
	input  wire logic i_refclk_output_oe,
	// observations
	output int        o_edges,
	output int        o_period_ns
	);
	timeunit 1ns;
	timeprecision 1ps;
	time last_rise = 0;
	initial
	begin
		o_edges     = 0;
		o_period_ns = 0;
	end
	// an undriven pin clocks nothing
	always @(posedge i_refclk_output_pin)
	begin
		if (i_refclk_output_oe === 1'b1)
		begin
			o_period_ns = int'($time - last_rise);
			last_rise   = $time;
			o_edges++;
		end
	end
endmodule

// ---- tb/rcg_refclk_gen_sva.sv ----
// checker on the generator top ports
// assumes i_clk_en is held high by the bench
module rcg_refclk_gen_sva
	import rcg_pkg::*;
	(
	// clock, reset, bus
	input wire logic        i_ref_clk,
	input wire logic        i_rst_n,
	input wire logic [3:0]  i_avs_address,
	input wire logic        i_avs_read,
	input wire logic        i_avs_write,
	input wire logic [31:0] o_avs_readdata,
	input wire logic        o_avs_waitrequest,
	// power, config, pins
	input wire logic        i_sleep_mode,
	input wire logic [6:0]  i_src_runs_in_sleep,
	input wire logic        i_pll_source_split,
	input wire logic        i_sysclk_output_config,
	input wire logic        o_refclk_output_pin,
	input wire logic        o_refclk_output_oe,
	input wire logic        o_sysclk_half_output,
	input wire logic        o_pll_primary_excluded
	);
	logic [3:0] rd_addr_reg, rd_addr_next;
	logic [7:0] quiet_reg, quiet_next;
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rst_n);
	// readdata holds, so remember which read it belongs to
	always_comb
	begin
		rd_addr_next = (i_avs_read && o_avs_waitrequest) ? i_avs_address : rd_addr_reg;
		quiet_next   = 8'h00;
		if (i_sleep_mode && i_src_runs_in_sleep == 7'h00)
			quiet_next = (quiet_reg == 8'hff) ? quiet_reg : quiet_reg + 8'h01;
	end
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			rd_addr_reg <= 4'h0;
			quiet_reg   <= 8'h00;
		end
		else
		begin
			rd_addr_reg <= rd_addr_next;
			quiet_reg   <= quiet_next;
		end
	end
	property p_ack_once;
		(i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest ##1 o_avs_waitrequest;
	endproperty
	a_ack_once: assert property (p_ack_once) else $error("bus answer not one cycle");
	property p_no_ack;
		!(i_avs_read || i_avs_write) && o_avs_waitrequest |=> o_avs_waitrequest;
	endproperty
	a_no_ack: assert property (p_no_ack) else $error("answer without request");
	property p_read_zero;
		!o_avs_waitrequest |-> o_avs_readdata[31:16] == 16'h0000
			&& (rd_addr_reg != 4'h0 || (o_avs_readdata[14] == 1'b0 && o_avs_readdata[10] == 1'b0
			&& o_avs_readdata[7:4] == 4'h0)) && (rd_addr_reg inside {4'h0, 4'h4, 4'h8} || o_avs_readdata == 32'h0);
	endproperty
	a_read_zero: assert property (p_read_zero) else $error("unused read bits set");
	property p_pin_gated;
		!o_refclk_output_oe |-> !o_refclk_output_pin;
	endproperty
	a_pin_gated: assert property (p_pin_gated) else $error("pin toggles while not driven");
	property p_half_toggle;
		$past(i_rst_n, 2) && $past(i_sysclk_output_config) |-> o_sysclk_half_output != $past(o_sysclk_half_output);
	endproperty
	a_half_toggle: assert property (p_half_toggle) else $error("half output not toggling");
	property p_half_off;
		$past(i_rst_n) && !$past(i_sysclk_output_config) |-> !o_sysclk_half_output;
	endproperty
	a_half_off: assert property (p_half_off) else $error("half output active when off");
	property p_pll_excl;
		$past(i_rst_n, 2) |-> o_pll_primary_excluded == !$past(i_pll_source_split);
	endproperty
	a_pll_excl: assert property (p_pll_excl) else $error("pll exclusion wrong");
	property p_sleep_quiet;
		quiet_reg >= 8'h78 |-> !o_refclk_output_pin;
	endproperty
	a_sleep_quiet: assert property (p_sleep_quiet) else $error("output runs in sleep");
	c_write: cover property (i_avs_write && !o_avs_waitrequest);
	c_rise: cover property ($rose(o_refclk_output_pin));
	c_quiet: cover property (quiet_reg == 8'h78);
endmodule
bind rcg_refclk_gen rcg_refclk_gen_sva u_sva (
	.i_ref_clk, .i_rst_n, .i_avs_address, .i_avs_read, .i_avs_write, .o_avs_readdata,
	.o_avs_waitrequest, .i_sleep_mode, .i_src_runs_in_sleep, .i_pll_source_split,
	.i_sysclk_output_config, .o_refclk_output_pin, .o_refclk_output_oe,
	.o_sysclk_half_output, .o_pll_primary_excluded
);

// ---- tb/reference_clock_output_generator_test.sv ----
// self-checking bench: bus tasks, source clocks, period checks
// assumes the partner model reports edges and period in ns
module reference_clock_output_generator_test
	import rcg_pkg::*;
	();
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LANE_OF [16] = '{0, -1, 1, 2, 3, 4, 5, -1, 6, -1, -1, -1, -1, -1, -1, -1};
	logic        i_ref_clk, i_rst_n, i_avs_read, i_avs_write, o_avs_waitrequest;
	logic        i_idle_mode, i_sleep_mode, i_pll_source_split, i_sysclk_output_config;
	logic        o_refclk_output_pin, o_refclk_output_oe;
	logic [3:0]  i_avs_address;
	logic [31:0] i_avs_writedata, o_avs_readdata;
	logic [6:0]  src, i_src_runs_in_sleep;
	logic [15:0] d, rv;
	int          edges, period_ns, seed;
	int          miscompares = 0;
	int          check_count = 0;
	int          cycles = 0;
	rcg_refclk_gen dut (
		.i_ref_clk, .i_rst_n, .i_clk_en(1'b1), .i_avs_address, .i_avs_read, .i_avs_write,
		.i_avs_writedata, .i_avs_byteenable(4'hf), .o_avs_readdata, .o_avs_waitrequest,
		.i_sysclk(src[0]), .i_primary_oscillator(src[1]), .i_fast_rc_oscillator(src[2]),
		.i_low_power_rc_oscillator(src[3]), .i_secondary_oscillator(src[4]), .i_pll_clk(src[5]),
		.i_refclk_input_pin(src[6]), .i_idle_mode, .i_sleep_mode, .i_src_runs_in_sleep,
		.i_pll_source_split, .i_sysclk_output_config, .o_refclk_output_pin, .o_refclk_output_oe,
		.o_sysclk_half_output(), .o_pll_primary_excluded()
	);
	rcg_ext_device ext (.i_refclk_output_pin(o_refclk_output_pin),
		.i_refclk_output_oe(o_refclk_output_oe), .o_edges(edges), .o_period_ns(period_ns));
	initial
	begin
		i_ref_clk = 1'b0;
		forever #4 i_ref_clk = ~i_ref_clk;
	end
	// slow sources, off the register clock edges except lanes 1 and 5; half period 3+k cycles
	for (genvar k = 0; k < 7; k++)
	begin : g_src
		initial
		begin
			src[k] = 1'b0;
			#(3 + k);
			forever #(8 * (3 + k)) src[k] = ~src[k];
		end
	end
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic check16(input string what, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic check_int(input string what, input int exp, input int got);
		check_count++;
		if (got != exp)
		begin
			miscompares++;
			$display("BAD %s expected %0d seen %0d", what, exp, got);
		end
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] v);
		@(posedge i_ref_clk);
		i_avs_address   <= a;
		i_avs_writedata <= {16'h0000, v};
		i_avs_write     <= w;
		i_avs_read      <= !w;
		do
			@(posedge i_ref_clk);
		while (o_avs_waitrequest !== 1'b0);
		d = o_avs_readdata[15:0];
		i_avs_write <= 1'b0;
		i_avs_read  <= 1'b0;
	endtask
	task automatic poll(input int b, input logic v);
		int n;
		n = 0;
		do
		begin
			bus(1'b0, RCG_OFF_CTRL_LOW, 16'h0000);
			n++;
		end
		while (d[b] !== v && n < 100);
		check16("status bit", {15'h0000, v}, {15'h0000, d[b]});
	endtask
	// values only change while stopped
	task automatic start(input logic [3:0] sel, input logic [14:0] n, input logic [8:0] t);
		bus(1'b1, RCG_OFF_CTRL_HIGH, {1'b0, n});
		bus(1'b1, RCG_OFF_TRIM, {t, 7'h00});
		bus(1'b1, RCG_OFF_CTRL_LOW, {12'h120, sel});
		poll(RCG_BIT_SWITCH_REQ, 1'b0);
		bus(1'b1, RCG_OFF_CTRL_LOW, {12'h900, sel});
		poll(RCG_BIT_ACTIVE, 1'b1);
	endtask
	task automatic stop(input logic [3:0] sel);
		bus(1'b1, RCG_OFF_CTRL_LOW, {12'h100, sel});
		poll(RCG_BIT_ACTIVE, 1'b0);
	endtask
	function automatic int exp_period(input logic [3:0] code, input int n, input int half);
		int lane;
		lane = (code == RCG_SRC_PLL && i_pll_source_split) ? 0 : LANE_OF[code];
		if (lane < 0)
			return 0;
		return (n == 0) ? 16 * (3 + lane) : 16 * (3 + lane) * (2 * n + half);
	endfunction
	task automatic run_check(input int exp);
		int e0;
		repeat (40) @(posedge i_ref_clk);
		e0 = edges;
		if (exp == 0)
		begin
			repeat (300) @(posedge i_ref_clk);
			check_int("edge count", e0, edges);
		end
		else
		begin
			repeat (2000)
				if (edges < e0 + 3)
					@(posedge i_ref_clk);
			check_int("edges seen", 1, int'(edges >= e0 + 3));
			check_int("period ns", exp, period_ns);
		end
	endtask
	always @(posedge i_ref_clk)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			miscompares++;
			conclude();
		end
	end
	initial
	begin
		seed = 31563;
		{i_rst_n, i_avs_read, i_avs_write, i_idle_mode, i_sleep_mode} = '0;
		{i_pll_source_split, i_sysclk_output_config, i_avs_address, i_avs_writedata} = '0;
		i_src_runs_in_sleep = 7'h7f;
		repeat (10) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		for (int a = 0; a < 16; a += 4)
		begin
			bus(1'b0, a[3:0], 16'h0000);
			check16("reset value", 16'h0000, d);
		end
		bus(1'b1, 4'hc, 16'hffff);
		bus(1'b0, 4'hc, 16'h0000);
		check16("unmapped", 16'h0000, d);
		bus(1'b1, RCG_OFF_CTRL_LOW, 16'h44f0);
		bus(1'b0, RCG_OFF_CTRL_LOW, 16'h0000);
		check16("unused bits", 16'h0000, d);
		repeat (6)
		begin
			rv = 16'($random(seed));
			i_pll_source_split     <= rv[0];
			i_sysclk_output_config <= rv[1];
			bus(1'b1, RCG_OFF_CTRL_HIGH, rv);
			bus(1'b0, RCG_OFF_CTRL_HIGH, 16'h0000);
			check16("divider", {1'b0, rv[14:0]}, d);
			bus(1'b1, RCG_OFF_TRIM, rv);
			bus(1'b0, RCG_OFF_TRIM, 16'h0000);
			check16("trim", rv & 16'hff80, d);
		end
		$display("register test done");
		for (int n = 0; n < 4; n++)
		begin
			start(RCG_SRC_PRIMARY_OSCILLATOR, n[14:0], 9'h000);
			run_check(exp_period(RCG_SRC_PRIMARY_OSCILLATOR, n, 0));
			stop(RCG_SRC_PRIMARY_OSCILLATOR);
		end
		start(RCG_SRC_PRIMARY_OSCILLATOR, 15'h0002, 9'h100);
		run_check(exp_period(RCG_SRC_PRIMARY_OSCILLATOR, 2, 1));
		stop(RCG_SRC_PRIMARY_OSCILLATOR);
		$display("divider test done");
		for (int c = 0; c < 16; c++)
		begin
			rv = 16'($random(seed));
			i_pll_source_split     <= rv[0];
			i_sysclk_output_config <= rv[1];
			start(c[3:0], {14'h0000, rv[2]} + 15'h0001, 9'h000);
			run_check(exp_period(c[3:0], int'(rv[2]) + 1, 0));
			stop(c[3:0]);
		end
		$display("source test done");
		start(RCG_SRC_PRIMARY_OSCILLATOR, 15'h0001, 9'h000);
		i_sleep_mode        <= 1'b1;
		i_src_runs_in_sleep <= 7'h00;
		run_check(0);
		bus(1'b1, RCG_OFF_CTRL_LOW, 16'h9802);
		i_src_runs_in_sleep <= 7'h02;
		run_check(exp_period(RCG_SRC_PRIMARY_OSCILLATOR, 1, 0));
		i_sleep_mode <= 1'b0;
		bus(1'b1, RCG_OFF_CTRL_LOW, 16'hb002);
		i_idle_mode <= 1'b1;
		run_check(0);
		bus(1'b1, RCG_OFF_CTRL_LOW, 16'h9002);
		run_check(exp_period(RCG_SRC_PRIMARY_OSCILLATOR, 1, 0));
		i_idle_mode <= 1'b0;
		bus(1'b1, RCG_OFF_CTRL_LOW, 16'h8002);
		run_check(0);
		stop(RCG_SRC_PRIMARY_OSCILLATOR);
		run_check(0);
		$display("power test done");
		conclude();
	end
endmodule
